// ---- hw/aur_defines.svh ----
// Constants of the auxiliary serial port and its controller
`ifndef AUR_DEFINES_SVH
`define AUR_DEFINES_SVH

// Baud reference and oversampling
`define AUR_XTAL_HZ        3686400
`define AUR_OVERSAMPLE     16
// Baud rates per selection code, in tenths of a baud
`define AUR_BAUD10_C1      1100
`define AUR_BAUD10_C2      1344
`define AUR_BAUD10_C3      1500
`define AUR_BAUD10_C4      3000
`define AUR_BAUD10_C5      6000
`define AUR_BAUD10_C6      12000
`define AUR_BAUD10_C7      20000
`define AUR_BAUD10_C8      24000
`define AUR_BAUD10_C9      48000
`define AUR_BAUD10_C10     72000
`define AUR_BAUD10_C11     96000
`define AUR_BAUD10_C12     192000

// Device register indices
`define AUR_REG_MODE1      3'h0
`define AUR_REG_MODE2      3'h1
`define AUR_REG_BAUD       3'h2
`define AUR_REG_CMD        3'h3
`define AUR_REG_STATUS     3'h4
`define AUR_REG_IRQ        3'h5
`define AUR_REG_DATA       3'h6

// Reset values
`define AUR_MODE1_RST      8'h57
`define AUR_MODE2_RST      8'h07
`define AUR_BAUD_RST       4'hB

// First mode register fields
`define AUR_M1_LEN_LSB     0
`define AUR_M1_PAR_ODD     2
`define AUR_M1_PAR_LSB     3
`define AUR_M1_AUTO_RTS    7
// Second mode register fields
`define AUR_M2_STOP2       3
`define AUR_M2_CTS_EN      4
`define AUR_M2_CHAN_LSB    6
`define AUR_CHAN_ECHO      2'h1

// Command register fields
`define AUR_CMD_RX_EN      0
`define AUR_CMD_RX_DIS     1
`define AUR_CMD_TX_EN      2
`define AUR_CMD_TX_DIS     3
`define AUR_CMD_MISC_LSB   4
`define AUR_MISC_RST_RX    3'h1
`define AUR_MISC_RST_TX    3'h2
`define AUR_MISC_RST_ERR   3'h3
`define AUR_MISC_MPO_HIGH  3'h4
`define AUR_MISC_MPO_LOW   3'h5

// Status bits
`define AUR_ST_RX_RDY      0
`define AUR_ST_TX_RDY      2
`define AUR_ST_TX_EMPTY    3
`define AUR_ST_OVERRUN     4
`define AUR_ST_PARITY      5
`define AUR_ST_FRAMING     6

// Controller Wishbone byte offsets
`define AUR_WB_LINK_CTL    8'h20
`define AUR_WB_IRQ_STAT    8'h24
`define AUR_WB_IRQ_MASK    8'h28
`define AUR_EV_DEV_IRQ     0
`define AUR_EV_TURNAROUND  1

`endif

// ---- hw/aur_pkg.sv ----
// Types of the auxiliary serial port and its controller
package aur_pkg;

   typedef enum logic [4:0] {
      TX_IDLE  = 5'h01,
      TX_START = 5'h02,
      TX_DATA  = 5'h04,
      TX_PAR   = 5'h08,
      TX_STOP  = 5'h10
   } aur_tx_st_t;

   typedef enum logic [4:0] {
      RX_IDLE  = 5'h01,
      RX_START = 5'h02,
      RX_DATA  = 5'h04,
      RX_PAR   = 5'h08,
      RX_STOP  = 5'h10
   } aur_rx_st_t;

   typedef enum logic [3:0] {
      H_IDLE    = 4'h1,
      H_STROBE  = 4'h2,
      H_CAPTURE = 4'h4,
      H_ACK     = 4'h8
   } aur_host_st_t;

   typedef struct packed {
      logic       xtalS1;
      logic       xtalS2;
      logic       xtalS3;
      logic       rxdS1;
      logic       rxdS2;
      logic       mpiS1;
      logic       mpiS2;
      logic [7:0] mode1;
      logic [7:0] mode2;
      logic [3:0] baud;
      logic [7:0] imr;
      logic [11:0] divCnt;
      logic       tick;
      logic       txEn;
      logic       rxEn;
      logic [7:0] thr;
      logic       thrFull;
      aur_tx_st_t txSt;
      logic [7:0] txShift;
      logic       txPar;
      logic [3:0] txCnt;
      logic [2:0] txBit;
      logic       txd;
      aur_rx_st_t rxSt;
      logic [7:0] rxShift;
      logic       rxParBad;
      logic [3:0] rxCnt;
      logic [2:0] rxBit;
      logic [7:0] rhr;
      logic       rxReady;
      logic       ovr;
      logic       parErr;
      logic       frmErr;
      logic       multipurpose_output_pin;
      logic [7:0] rdata;
      logic       irq;
      logic       txdPin;
      logic       mpoPin;
   } aur_dev_st_t;

   typedef struct packed {
      aur_host_st_t st;
      logic        ack;
      logic [31:0] datO;
      logic        irq;
      logic [2:0]  addr;
      logic        wr;
      logic        rd;
      logic [7:0]  wdata;
      logic        devSel;
      logic        rs485;
      logic [1:0]  irqStat;
      logic [1:0]  irqMask;
      logic        devIrqPrev;
   } aur_host_st_t_s_t;

endpackage : aur_pkg

// ---- hw/aur_if.sv ----
// Register and interrupt link between controller and serial port
`timescale 1ns/1ps
`default_nettype none
interface aur_if;
   logic [2:0] regAddr;
   logic       regWr;
   logic       regRd;
   logic [7:0] regWdata;
   logic [7:0] regRdata;
   logic       extIrqZero;

   modport dev  (input regAddr, regWr, regRd, regWdata, output regRdata, extIrqZero);
   modport host (output regAddr, regWr, regRd, regWdata, input regRdata, extIrqZero);
endinterface : aur_if
`default_nettype wire

// ---- hw/aur_device.sv ----
// Auxiliary serial port: framing, baud generation, registers, interrupt
// Functional notes
// [R1] Bit timing from separate 3.6864 MHz crystal
// [R2] Codes 1 to 12 select 110..19200 baud
// [R3] Interrupt delivery; unserviced bytes overflow, lost
// [R4] 0x57/0x07 give 8N1, normal, no flow
// [R5] Echo, parity, 2 stop, 5 bits, flow
// [R6] Service requests on external interrupt zero, maskable
// [R7] Both directions disabled until explicitly enabled
// [R8] RS232: host enables both for full duplex
// [R9] RS485: host never enables both directions together
// [R10] Output high transmit, low receive for driver
// [R11] Same output usable as host-set RTS
// [R12] Direction reset commands idle and disable it
// [R13] Framing, parity, overrun errors readable
// [R14] Ready interrupts only when truly ready
//
// Implementation choices: the address map and the Wishbone slave port.
`include "aur_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module aur_device (
   // Clock and reset
   input  wire logic mclk,
   input  wire logic rstn,
   // Register and interrupt link
   aur_if.dev        bus,
   // Line side
   input  wire logic xtalIn,
   input  wire logic rxdPin,
   input  wire logic mpiPin,
   output logic      txdPin,
   output logic      mpoPin
);
   import aur_pkg::*;

   localparam aur_dev_st_t DEV_RST = '{
      mode1:   `AUR_MODE1_RST,
      mode2:   `AUR_MODE2_RST,
      baud:    `AUR_BAUD_RST,
      txSt:    TX_IDLE,
      rxSt:    RX_IDLE,
      rxdS1:   1'b1,
      rxdS2:   1'b1,
      txd:     1'b1,
      txdPin:  1'b1,
      default: '0
   };

   function automatic logic [11:0] baudDiv(input logic [3:0] code);
      int b10;
      b10 = 0;
      case (code)
         4'h1:    b10 = `AUR_BAUD10_C1;
         4'h2:    b10 = `AUR_BAUD10_C2;
         4'h3:    b10 = `AUR_BAUD10_C3;
         4'h4:    b10 = `AUR_BAUD10_C4;
         4'h5:    b10 = `AUR_BAUD10_C5;
         4'h6:    b10 = `AUR_BAUD10_C6;
         4'h7:    b10 = `AUR_BAUD10_C7;
         4'h8:    b10 = `AUR_BAUD10_C8;
         4'h9:    b10 = `AUR_BAUD10_C9;
         4'hA:    b10 = `AUR_BAUD10_C10;
         4'hB:    b10 = `AUR_BAUD10_C11;
         4'hC:    b10 = `AUR_BAUD10_C12;
         default: b10 = 0;
      endcase
      // Rounded crystal divisor for one oversample tick; zero halts the divider
      if (b10 == 0) begin
         return 12'h000;
      end
      return 12'((`AUR_XTAL_HZ * 10 + (`AUR_OVERSAMPLE / 2) * b10) / (`AUR_OVERSAMPLE * b10));
   endfunction : baudDiv

   function automatic logic parityBit(input logic [7:0] d, input logic [1:0] len,
                                      input logic odd);
      return (^(d & (8'hFF >> (2'h3 - len)))) ^ odd;
   endfunction : parityBit

   aur_dev_st_t r;
   aur_dev_st_t n;
   logic [7:0]  stat;
   logic [2:0]  lastBit;
   logic [11:0] div;
   logic [7:0]  rxData;
   logic        xtalEdge;
   logic        parOn;
   logic        ctsOk;
   logic        store;
   logic [2:0]  misc;

   always_comb begin
      n = r;
      n.tick = 1'b0;
      lastBit = 3'(r.mode1[`AUR_M1_LEN_LSB +: 2]) + 3'h4;
      parOn = (r.mode1[`AUR_M1_PAR_LSB +: 2] == 2'h0);
      ctsOk = !r.mode2[`AUR_M2_CTS_EN] || !r.mpiS2;
      div = baudDiv(r.baud);
      xtalEdge = r.xtalS2 && !r.xtalS3;
      rxData = r.rxShift >> (2'h3 - r.mode1[`AUR_M1_LEN_LSB +: 2]);
      store = 1'b0;
      misc = bus.regWdata[`AUR_CMD_MISC_LSB +: 3];
      stat = 8'h00;
      stat[`AUR_ST_RX_RDY] = r.rxReady;
      stat[`AUR_ST_TX_RDY] = r.txEn && !r.thrFull; // [R14]
      stat[`AUR_ST_TX_EMPTY] = r.txEn && !r.thrFull && (r.txSt == TX_IDLE);
      stat[`AUR_ST_OVERRUN] = r.ovr; // [R13]
      stat[`AUR_ST_PARITY] = r.parErr; // [R13]
      stat[`AUR_ST_FRAMING] = r.frmErr; // [R13]

      // Crystal and line inputs come from outside the clock domain
      n.xtalS1 = xtalIn;
      n.xtalS2 = r.xtalS1;
      n.xtalS3 = r.xtalS2;
      n.rxdS1 = rxdPin;
      n.rxdS2 = r.rxdS1;
      n.mpiS1 = mpiPin;
      n.mpiS2 = r.mpiS1;

      // Divider counts crystal edges, so rates track the crystal, not mclk
      if (xtalEdge && div != 12'h000) begin // [R1] [R2]
         if (r.divCnt >= div - 12'h001) begin
            n.divCnt = 12'h000;
            n.tick = 1'b1;
         end else begin
            n.divCnt = r.divCnt + 12'h001;
         end
      end

      // Transmitter
      if (r.tick) begin
         if (r.txSt != TX_IDLE) begin
            n.txCnt = r.txCnt + 4'h1;
         end
         unique case (r.txSt)
            TX_IDLE: if (r.txEn && r.thrFull && ctsOk) begin // [R7] [R5]
               n.txShift = r.thr;
               n.txPar = parityBit(r.thr, r.mode1[`AUR_M1_LEN_LSB +: 2],
                                   r.mode1[`AUR_M1_PAR_ODD]); // [R5]
               n.thrFull = 1'b0;
               n.txd = 1'b0;
               // Counter may be stale after a tx reset cut a frame
               n.txCnt = 4'h0; // [R12]
               n.txSt = TX_START;
            end
            TX_START: if (r.txCnt == 4'hF) begin
               n.txd = r.txShift[0];
               n.txBit = 3'h0;
               n.txSt = TX_DATA;
            end
            TX_DATA: if (r.txCnt == 4'hF) begin
               if (r.txBit == lastBit) begin // [R5]
                  n.txd = parOn ? r.txPar : 1'b1;
                  n.txSt = parOn ? TX_PAR : TX_STOP;
                  n.txBit = 3'h0;
               end else begin
                  n.txShift = r.txShift >> 1;
                  n.txd = r.txShift[1];
                  n.txBit = r.txBit + 3'h1;
               end
            end
            TX_PAR: if (r.txCnt == 4'hF) begin
               n.txd = 1'b1;
               n.txSt = TX_STOP;
            end
            TX_STOP: if (r.txCnt == 4'hF) begin
               if (r.mode2[`AUR_M2_STOP2] && r.txBit == 3'h0) begin // [R5]
                  n.txBit = 3'h1;
               end else begin
                  n.txSt = TX_IDLE;
               end
            end
         endcase
      end

      // Receiver samples mid-bit on the sixteenth-rate tick
      if (r.tick) begin
         if (r.rxSt != RX_IDLE) begin
            n.rxCnt = r.rxCnt + 4'h1;
         end
         unique case (r.rxSt)
            RX_IDLE: if (r.rxEn && !r.rxdS2) begin // [R7]
               n.rxCnt = 4'h0;
               n.rxSt = RX_START;
            end
            RX_START: if (r.rxCnt == 4'h7) begin
               n.rxCnt = 4'h0;
               n.rxBit = 3'h0;
               n.rxSt = r.rxdS2 ? RX_IDLE : RX_DATA;
            end
            RX_DATA: if (r.rxCnt == 4'hF) begin
               n.rxShift = {r.rxdS2, r.rxShift[7:1]};
               n.rxBit = r.rxBit + 3'h1;
               if (r.rxBit == lastBit) begin
                  n.rxSt = parOn ? RX_PAR : RX_STOP;
               end
            end
            RX_PAR: if (r.rxCnt == 4'hF) begin
               n.rxParBad = r.rxdS2 != parityBit(rxData, r.mode1[`AUR_M1_LEN_LSB +: 2],
                                                 r.mode1[`AUR_M1_PAR_ODD]);
               n.rxSt = RX_STOP;
            end
            RX_STOP: if (r.rxCnt == 4'hF) begin
               store = 1'b1;
               n.rxSt = RX_IDLE;
            end
         endcase
      end

      // Register reads answer one cycle after the strobe
      if (bus.regRd) begin
         unique case (bus.regAddr)
            `AUR_REG_MODE1:  n.rdata = r.mode1;
            `AUR_REG_MODE2:  n.rdata = r.mode2;
            `AUR_REG_BAUD:   n.rdata = {4'h0, r.baud};
            `AUR_REG_STATUS: n.rdata = stat;
            `AUR_REG_IRQ:    n.rdata = stat & r.imr; // [R6]
            `AUR_REG_DATA: begin
               n.rdata = r.rhr;
               n.rxReady = 1'b0;
            end
            default:         n.rdata = 8'h00;
         endcase
      end

      if (bus.regWr) begin
         unique case (bus.regAddr)
            `AUR_REG_MODE1: n.mode1 = bus.regWdata; // [R4] [R5]
            `AUR_REG_MODE2: n.mode2 = bus.regWdata; // [R4] [R5]
            `AUR_REG_BAUD:  n.baud = bus.regWdata[3:0]; // [R2]
            `AUR_REG_IRQ:   n.imr = bus.regWdata; // [R6]
            `AUR_REG_DATA: if (r.txEn && !r.thrFull) begin // [R7]
               n.thr = bus.regWdata;
               n.thrFull = 1'b1;
            end
            `AUR_REG_CMD: begin
               // Disable wins when both enable and disable are written
               if (bus.regWdata[`AUR_CMD_RX_EN]) n.rxEn = 1'b1; // [R7]
               if (bus.regWdata[`AUR_CMD_TX_EN]) n.txEn = 1'b1; // [R7]
               if (bus.regWdata[`AUR_CMD_RX_DIS]) begin
                  n.rxEn = 1'b0;
                  n.rxSt = RX_IDLE;
               end
               if (bus.regWdata[`AUR_CMD_TX_DIS]) n.txEn = 1'b0;
               unique case (misc)
                  `AUR_MISC_RST_RX: begin // [R12]
                     n.rxEn = 1'b0;
                     n.rxSt = RX_IDLE;
                     n.rxReady = 1'b0;
                  end
                  `AUR_MISC_RST_TX: begin // [R12]
                     n.txEn = 1'b0;
                     n.txSt = TX_IDLE;
                     n.thrFull = 1'b0;
                     n.txd = 1'b1;
                  end
                  `AUR_MISC_RST_ERR: begin
                     n.ovr = 1'b0;
                     n.parErr = 1'b0;
                     n.frmErr = 1'b0;
                  end
                  `AUR_MISC_MPO_HIGH: n.multipurpose_output_pin = 1'b1; // [R10] [R11]
                  `AUR_MISC_MPO_LOW:  n.multipurpose_output_pin = 1'b0; // [R10] [R11]
                  default: ;
               endcase
            end
            default: ;
         endcase
      end

      // Placed after clears so a new event in the same cycle survives
      if (store && n.rxEn) begin
         if (n.rxReady) begin
            n.ovr = 1'b1; // [R3] [R13]
         end else begin
            n.rhr = rxData;
            n.rxReady = 1'b1;
         end
         if (!r.rxdS2) n.frmErr = 1'b1; // [R13]
         if (parOn && r.rxParBad) n.parErr = 1'b1; // [R13]
      end

      n.irq = |(stat & r.imr); // [R6] [R14]
      // Echo mode retransmits the line and mutes the local transmitter
      n.txdPin = (r.mode2[`AUR_M2_CHAN_LSB +: 2] == `AUR_CHAN_ECHO) ? r.rxdS2 : r.txd; // [R5]
      // Automatic RTS drives the output low, the level CTS here reads as clear to send, while a character waits
      n.mpoPin = r.mode1[`AUR_M1_AUTO_RTS] ? !r.rxReady : r.multipurpose_output_pin; // [R5] [R10] [R11]
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         r <= DEV_RST;
      end else begin
         r <= n;
      end
   end

   assign bus.regRdata = r.rdata;
   assign bus.extIrqZero = r.irq;
   assign txdPin = r.txdPin;
   assign mpoPin = r.mpoPin;
endmodule : aur_device
`default_nettype wire

// ---- hw/aur_host.sv ----
// Controller end: Wishbone slave that drives the serial port's registers
`include "aur_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module aur_host (
   // Clock and reset
   input  wire logic        mclk,
   input  wire logic        rstn,
   // Wishbone slave
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [31:0] adr_i,
   input  wire logic [31:0] dat_i,
   input  wire logic [3:0]  sel_i,
   output logic      [31:0] dat_o,
   output logic             ack_o,
   // Interrupt to software
   output logic             hostIrq,
   // Serial port link
   aur_if.host              bus
);
   import aur_pkg::*;

   localparam aur_host_st_t_s_t HOST_RST = '{st: H_IDLE, default: '0};

   aur_host_st_t_s_t r;
   aur_host_st_t_s_t n;
   logic [1:0]       ev;
   logic [1:0]       clr;
   logic [7:0]       cmd;
   logic             devHit;
   logic             ownWr;

   always_comb begin
      n = r;
      n.wr = 1'b0;
      n.rd = 1'b0;
      ev = 2'h0;
      clr = 2'h0;
      cmd = dat_i[7:0];
      devHit = (adr_i[31:5] == 27'h0);
      ownWr = we_i && sel_i[0];
      ev[`AUR_EV_DEV_IRQ] = bus.extIrqZero && !r.devIrqPrev; // [R3] [R6]
      n.devIrqPrev = bus.extIrqZero;

      // Half duplex: opening one direction closes the other and turns the driver
      if (r.rs485 && adr_i[4:2] == `AUR_REG_CMD) begin
         if (dat_i[`AUR_CMD_TX_EN]) begin // [R9] [R10]
            cmd[`AUR_CMD_RX_EN] = 1'b0;
            cmd[`AUR_CMD_RX_DIS] = 1'b1;
            cmd[`AUR_CMD_MISC_LSB +: 3] = `AUR_MISC_MPO_HIGH;
         end else if (dat_i[`AUR_CMD_RX_EN]) begin // [R9] [R10]
            cmd[`AUR_CMD_TX_DIS] = 1'b1;
            cmd[`AUR_CMD_MISC_LSB +: 3] = `AUR_MISC_MPO_LOW;
         end
      end

      unique case (r.st)
         H_IDLE: if (cyc_i && stb_i) begin
            n.st = H_STROBE;
            n.devSel = devHit;
            if (devHit) begin
               n.addr = adr_i[4:2];
               n.wr = ownWr; // [R8]
               n.rd = !we_i;
               n.wdata = cmd;
               if (ownWr && r.rs485 && cmd != dat_i[7:0]) begin
                  ev[`AUR_EV_TURNAROUND] = 1'b1;
               end
            end else if (ownWr) begin
               unique case (adr_i[7:0])
                  `AUR_WB_LINK_CTL: n.rs485 = dat_i[0];
                  `AUR_WB_IRQ_STAT: clr = dat_i[1:0];
                  `AUR_WB_IRQ_MASK: n.irqMask = dat_i[1:0];
                  default: ;
               endcase
            end
         end
         H_STROBE: n.st = H_CAPTURE;
         H_CAPTURE: begin
            n.ack = 1'b1;
            n.st = H_ACK;
            if (r.devSel) begin
               n.datO = {24'h0, bus.regRdata};
            end else begin
               unique case (adr_i[7:0])
                  `AUR_WB_LINK_CTL: n.datO = {31'h0, r.rs485};
                  `AUR_WB_IRQ_STAT: n.datO = {30'h0, r.irqStat};
                  `AUR_WB_IRQ_MASK: n.datO = {30'h0, r.irqMask};
                  default:          n.datO = 32'h0;
               endcase
            end
         end
         H_ACK: begin
            n.ack = 1'b0;
            n.st = H_IDLE;
         end
      endcase

      // Set beats clear so no event slips through a clear
      n.irqStat = (r.irqStat & ~clr) | ev;
      n.irq = |(r.irqStat & r.irqMask);
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         r <= HOST_RST;
      end else begin
         r <= n;
      end
   end

   assign dat_o = r.datO;
   assign ack_o = r.ack;
   assign hostIrq = r.irq;
   assign bus.regAddr = r.addr;
   assign bus.regWr = r.wr;
   assign bus.regRd = r.rd;
   assign bus.regWdata = r.wdata;
endmodule : aur_host
`default_nettype wire

// ---- dv/aur_assertions.sv ----
// Checker on the link between controller and serial port
`timescale 1ns/1ps
`default_nettype none
module aur_assertions (
   // Clock and reset
   input wire logic       mclk,
   input wire logic       rstn,
   // Register link
   input wire logic [2:0] regAddr,
   input wire logic       regWr,
   input wire logic       regRd,
   input wire logic [7:0] regWdata,
   input wire logic [7:0] regRdata,
   input wire logic       extIrqZero,
   // Line pins
   input wire logic       txdPin,
   input wire logic       mpoPin
);
   logic txSeen;
   logic maskZero;
   logic cmdWr;
   assign cmdWr = regWr && regAddr == 3'h3;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);
   // Only reset-tx clears: a plain disable may let a frame finish
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         txSeen   <= 1'b0;
         maskZero <= 1'b1;
      end else begin
         if (cmdWr) txSeen <= (txSeen || regWdata[2]) && regWdata[6:4] != 3'h2;
         if (regWr && regAddr == 3'h5) maskZero <= regWdata == 8'h00;
      end
   end
   reset_idle_a: assert property ($rose(rstn) |-> txdPin && !mpoPin && !extIrqZero)
      else $error("line or interrupt active after reset");
   tx_idle_a: assert property (!txSeen && !$past(txSeen) && !$past(txSeen, 2) |-> txdPin)
      else $error("serial output moved while transmitter disabled");
   mpo_high_a: assert property (cmdWr && regWdata[6:4] == 3'h4 |-> ##[1:3] mpoPin)
      else $error("output not raised by command");
   mpo_low_a: assert property (cmdWr && regWdata[6:4] == 3'h5 |-> ##[1:3] !mpoPin)
      else $error("output not lowered by command");
   irq_mask_a: assert property (maskZero && $past(maskZero) && $past(maskZero, 2) |-> !extIrqZero)
      else $error("interrupt with all sources masked");
   rdata_hold_a: assert property (!regRd |=> $stable(regRdata))
      else $error("read data changed without read");
   wr_pulse_a: assert property (regWr |=> !regWr && !regRd)
      else $error("write strobe longer than one cycle");
   rd_spacing_a: assert property (regRd |=> !regRd [*3])
      else $error("read strobes too close");
endmodule : aur_assertions
`default_nettype wire

// ---- dv/aux_uart_rs485_port_tb_top.sv ----
// Testbench: controller and serial port joined, line looped or driven
`timescale 1ns/1ps
`default_nettype none
module aux_uart_rs485_port_tb_top;
   // 16 ticks of 12 crystal edges, crystal at mclk/4 for speed
   localparam int          BIT_CYC = 768;
   localparam logic [31:0] ALL     = 32'hFFFFFFFF;
   logic        mclk;
   logic        rstn;
   logic        cyc;
   logic        stb;
   logic        we;
   logic [31:0] adr;
   logic [31:0] datW;
   logic [31:0] datR;
   logic        ack;
   logic        hostIrq;
   logic [1:0]  xDiv;
   logic        rxdDrv;
   logic        loop;
   logic        txdPin;
   logic        mpoPin;
   logic        rxd;
   logic        multipurpose_input_pin;
   int          failures;
   int          checkCount;
   int          lowRun;
   int          lastRun;
   aur_if aur_if_inst ();
   assign rxd = loop ? txdPin : rxdDrv;
   aur_device aur_device_inst (.mclk(mclk), .rstn(rstn), .bus(aur_if_inst.dev),
      .xtalIn(xDiv[1]), .rxdPin(rxd), .mpiPin(multipurpose_input_pin), .txdPin(txdPin), .mpoPin(mpoPin));
   aur_host aur_host_inst (.mclk(mclk), .rstn(rstn), .cyc_i(cyc), .stb_i(stb), .we_i(we),
      .adr_i(adr), .dat_i(datW), .sel_i(4'hF), .dat_o(datR), .ack_o(ack), .hostIrq(hostIrq),
      .bus(aur_if_inst.host));
   aur_assertions aur_assertions_inst (.mclk(mclk), .rstn(rstn),
      .regAddr(aur_if_inst.regAddr), .regWr(aur_if_inst.regWr), .regRd(aur_if_inst.regRd),
      .regWdata(aur_if_inst.regWdata), .regRdata(aur_if_inst.regRdata),
      .extIrqZero(aur_if_inst.extIrqZero), .txdPin(txdPin), .mpoPin(mpoPin));
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   // Low-run length of the line gives the bit time
   always @(posedge mclk) begin
      xDiv <= xDiv + 2'h1;
      if (!txdPin) lowRun <= lowRun + 1;
      else if (lowRun != 0) begin
         lastRun <= lowRun;
         lowRun  <= 0;
      end
   end
   task automatic final_report();
      $display("checks %0d mismatches %0d", checkCount, failures);
      if (failures == 0 && checkCount > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : final_report
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checkCount++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic chk1(input logic v, input logic e);
      chk({31'h0, v}, {31'h0, e});
   endtask : chk1
   task automatic wb(input logic [7:0] a, input logic w, input logic [7:0] d,
                     output logic [31:0] q);
      int n;
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= w;
      adr  <= {24'h000000, a};
      datW <= {24'h000000, d};
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (ack !== 1'b1 && n < 20);
      q = datR;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge mclk);
      if (n >= 20) begin
         failures++;
         final_report();
      end
   endtask : wb
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] q;
      wb(a, 1'b1, d, q);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      logic [31:0] q;
      wb(a, 1'b0, 8'h00, q);
      chk(q & m, e);
   endtask : rd
   task automatic wait_bit(input int b);
      logic [31:0] q;
      int n;
      n = 0;
      do begin
         wb(8'h10, 1'b0, 8'h00, q);
         n++;
      end while (q[b] !== 1'b1 && n < 4000);
      chk1(q[b], 1'b1);
      if (n >= 4000) final_report();
   endtask : wait_bit
   task automatic send_bits(input logic [10:0] w, input int n);
      for (int i = 0; i < n; i++) begin
         rxdDrv <= w[i];
         repeat (BIT_CYC) @(posedge mclk);
      end
      rxdDrv <= 1'b1;
      repeat (BIT_CYC) @(posedge mclk);
   endtask : send_bits
   task automatic test_reset();
      rd(8'h00, ALL, 32'h57);
      rd(8'h04, ALL, 32'h07);
      rd(8'h08, ALL, 32'h0B);
      rd(8'h10, 32'h5, 32'h0);
      wr(8'h1C, 8'hFF);
      rd(8'h1C, ALL, 32'h0);
      rd(8'h40, ALL, 32'h0);
      $display("test_reset done");
   endtask : test_reset
   task automatic test_loop();
      wr(8'h08, 8'h0C);
      loop <= 1'b1;
      wr(8'h0C, 8'h05);
      rd(8'h10, 32'h4, 32'h4);
      wr(8'h04, 8'h17);
      multipurpose_input_pin <= 1'b1;
      wr(8'h18, 8'hA5);
      repeat (200) @(posedge mclk);
      rd(8'h10, 32'h4, 32'h0);
      multipurpose_input_pin <= 1'b0;
      wr(8'h04, 8'h07);
      wait_bit(0);
      rd(8'h18, ALL, 32'hA5);
      chk1(lastRun >= BIT_CYC - 8 && lastRun <= BIT_CYC + 8, 1'b1);
      rd(8'h10, 32'h1, 32'h0);
      $display("test_loop done");
   endtask : test_loop
   task automatic test_errors();
      logic [31:0] q;
      wr(8'h18, 8'h11);
      wait_bit(2);
      wr(8'h18, 8'h22);
      wait_bit(4);
      rd(8'h18, ALL, 32'h11);
      wr(8'h0C, 8'h35);
      rd(8'h10, 32'h70, 32'h0);
      loop <= 1'b0;
      send_bits(11'h078, 10);
      wait_bit(6);
      wb(8'h18, 1'b0, 8'h00, q);
      // Even parity on, parity bit sent wrong
      wr(8'h00, 8'h43);
      send_bits(11'h678, 11);
      wait_bit(5);
      wb(8'h18, 1'b0, 8'h00, q);
      wr(8'h00, 8'h57);
      wr(8'h0C, 8'h35);
      rd(8'h10, 32'h71, 32'h0);
      loop <= 1'b1;
      $display("test_errors done");
   endtask : test_errors
   task automatic test_irq();
      wr(8'h24, 8'h03);
      wr(8'h28, 8'h01);
      wr(8'h14, 8'h01);
      chk1(hostIrq, 1'b0);
      wr(8'h18, 8'h5A);
      wait_bit(0);
      repeat (4) @(posedge mclk);
      chk1(hostIrq, 1'b1);
      rd(8'h14, ALL, 32'h01);
      wr(8'h28, 8'h00);
      repeat (2) @(posedge mclk);
      chk1(hostIrq, 1'b0);
      wr(8'h28, 8'h01);
      repeat (2) @(posedge mclk);
      chk1(hostIrq, 1'b1);
      rd(8'h18, ALL, 32'h5A);
      wr(8'h24, 8'h01);
      repeat (2) @(posedge mclk);
      chk1(hostIrq, 1'b0);
      $display("test_irq done");
   endtask : test_irq
   task automatic test_rs485();
      wr(8'h14, 8'h00);
      wr(8'h0C, 8'h40);
      repeat (3) @(posedge mclk);
      chk1(mpoPin, 1'b1);
      wr(8'h0C, 8'h50);
      repeat (3) @(posedge mclk);
      chk1(mpoPin, 1'b0);
      wr(8'h20, 8'h01);
      wr(8'h0C, 8'h04);
      rd(8'h24, 32'h2, 32'h2);
      chk1(mpoPin, 1'b1);
      // Looped line echoes the frame; receiver must stay off
      wr(8'h18, 8'h77);
      repeat (12 * BIT_CYC) @(posedge mclk);
      rd(8'h10, 32'h1, 32'h0);
      wr(8'h0C, 8'h01);
      chk1(mpoPin, 1'b0);
      rd(8'h10, 32'h4, 32'h0);
      wr(8'h0C, 8'h04);
      wr(8'h0C, 8'h20);
      rd(8'h10, 32'h4, 32'h0);
      $display("test_rs485 done");
   endtask : test_rs485
   initial begin
      rstn       = 1'b0;
      cyc        = 1'b0;
      stb        = 1'b0;
      we         = 1'b0;
      adr        = 32'h0;
      datW       = 32'h0;
      xDiv       = 2'h0;
      rxdDrv     = 1'b1;
      multipurpose_input_pin        = 1'b0;
      loop       = 1'b0;
      lowRun     = 0;
      lastRun    = 0;
      failures   = 0;
      checkCount = 0;
      repeat (10) @(posedge mclk);
      rstn <= 1'b1;
      @(posedge mclk);
      test_reset();
      test_loop();
      test_errors();
      test_irq();
      test_rs485();
      final_report();
   end
endmodule : aux_uart_rs485_port_tb_top
`default_nettype wire
